//--- hw/mbd_pkg.sv
package mbd_pkg;

  // ********************************************************************
  // register map, byte addresses on the wishbone slave
  // ********************************************************************
  localparam logic [7:0] OFS_CMD   = 8'h00;  // write launches an operation
  localparam logic [7:0] OFS_ACC   = 8'h04;  // accumulator
  localparam logic [7:0] OFS_FLAGS = 8'h08;  // status flags
  localparam logic [7:0] OFS_WDT   = 8'h0c;  // watchdog count and prescaler
  localparam logic [1:0] MEM_PAGE  = 2'h1;   // adr[7:6] selecting data memory at 0x40

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int CMD_OP_LSB   = 0;   // opcode in bits 2:0
  localparam int CMD_ADR_LSB  = 8;   // memory address in bits 11:8
  localparam int FLG_ZERO     = 0;   // null-result flag
  localparam int FLG_OVF      = 1;   // overflow-bit flag
  localparam int FLG_HALF     = 2;   // half_carry_flag
  localparam int FLG_SLEEP    = 3;   // sleep_entered_flag, read only
  localparam int FLG_WDOG     = 4;   // watchdog_expired_flag, read only
  localparam int WDT_PRE_LSB  = 8;   // prescaler in bits 15:8 of the wdt word

  // ********************************************************************
  // sizes, reset values and counts
  // ********************************************************************
  localparam int         MEM_WORDS = 16;
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] MEM_RST   = 8'h00;
  localparam logic [7:0] PRE_LAST  = 8'hff;  // prescaler divides by 256
  localparam logic [7:0] WDT_LAST  = 8'hff;  // timeout after 256 prescaler ticks
  localparam logic [3:0] NIB_MAX   = 4'h9;   // largest decimal digit
  localparam logic [3:0] NIB_FIX   = 4'h6;   // decimal correction per nibble

  // ********************************************************************
  // operations and power states
  // ********************************************************************
  typedef enum logic [2:0] {
    OP_NOP       = 3'b000,
    OP_INV_ACC   = 3'b001,  // invert_to_acc_op
    OP_BCD_ADJ   = 3'b010,  // bcd_adjust_op
    OP_MEM_DEC   = 3'b011,  // mem_minus_one_op
    OP_DEC_ACC   = 3'b100,  // minus_one_to_acc_op
    OP_SLEEP     = 3'b101,
    OP_MEM_INC   = 3'b110,
    OP_INC_ACC   = 3'b111   // plus_one_to_acc_op
  } mbd_op_t;

  typedef enum logic [0:0] {
    PWR_RUN   = 1'b0,
    PWR_SLEEP = 1'b1
  } mbd_pwr_t;

endpackage

//--- hw/mbd_alu.sv
`timescale 1ns/1ps
module mbd_alu
  import mbd_pkg::*;
(
  // operation and operands
  input  wire mbd_op_t    op,
  input  wire logic [7:0] accIn,
  input  wire logic [7:0] memIn,
  input  wire logic       ovfIn,
  input  wire logic       halfIn,
  // results
  output logic [7:0]      result,
  output logic            accWe,
  output logic            memWe,
  output logic            zeroWe,
  output logic            ovfOut
);

  // ********************************************************************
  // decimal correction terms
  // ********************************************************************
  logic       loFix;
  logic       hiFix;
  logic [8:0] bcdSum;

  // both nibble tests look at the accumulator before any correction
  always_comb begin
    loFix  = (accIn[3:0] > NIB_MAX) || halfIn;
    hiFix  = (accIn[7:4] > NIB_MAX) || ovfIn;
    bcdSum = {1'b0, accIn} + {1'b0, (hiFix ? NIB_FIX : 4'h0), (loFix ? NIB_FIX : 4'h0)};
  end

  // ********************************************************************
  // result and destination select
  // ********************************************************************
  always_comb begin
    result = memIn;
    accWe  = 1'b0;
    memWe  = 1'b0;
    zeroWe = 1'b0;
    ovfOut = ovfIn;
    case (op)
      OP_INV_ACC: begin
        result = ~memIn;
        accWe  = 1'b1;
        zeroWe = 1'b1;
      end
      OP_BCD_ADJ: begin
        result = bcdSum[7:0];
        memWe  = 1'b1;
        ovfOut = hiFix | bcdSum[8];  // chains multi-byte decimal sums
      end
      OP_MEM_DEC: begin
        result = memIn - 8'h01;
        memWe  = 1'b1;
        zeroWe = 1'b1;
      end
      OP_DEC_ACC: begin
        result = memIn - 8'h01;
        accWe  = 1'b1;
        zeroWe = 1'b1;
      end
      OP_MEM_INC: begin
        result = memIn + 8'h01;
        memWe  = 1'b1;
        zeroWe = 1'b1;
      end
      OP_INC_ACC: begin
        result = memIn + 8'h01;
        accWe  = 1'b1;
        zeroWe = 1'b1;
      end
      default: begin
        result = memIn;
      end
    endcase
  end

endmodule

//--- hw/mbd_core.sv
`timescale 1ns/1ps
module mbd_core
  import mbd_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // power control
  input  wire logic        wakePin,
  output logic             sysClkEn,
  output logic             sleepEntered,
  output logic             wdtExpired
);

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    logic                          ack;
    logic [31:0]                   rdat;
    logic [7:0]                    acc;
    logic                          zero;
    logic                          ovf;
    logic                          half;
    logic                          sleep_entered_flag;
    logic                          tmo;
    mbd_pwr_t                      pwr;
    logic                          clkEn;
    logic [MEM_WORDS-1:0][7:0]     mem;
    logic [7:0]                    pre;
    logic [7:0]                    wdt;
    logic [11:0]                   lastCmd;
    logic                          wake1;
    logic                          wake2;
  } mbd_state_t;

  mbd_state_t s_q;
  mbd_state_t s_d;

  // ********************************************************************
  // decode of the current bus request
  // ********************************************************************
  logic       busReq;
  logic       wrLow;
  logic       execGo;
  logic       preTick;
  logic       wdtTimeout;
  mbd_op_t    curOp;
  logic [3:0] opAddr;
  logic [7:0] opByte;
  logic [7:0] aluRes;
  logic       aluAccWe;
  logic       aluMemWe;
  logic       aluZeroWe;
  logic       aluOvf;

  // one ack per request; the s_q.ack term keeps a held strobe from acking on two cycles in a row
  always_comb begin
    busReq     = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wrLow      = busReq & wb_we_i & wb_sel_i[0];
    curOp      = mbd_op_t'(wb_dat_i[CMD_OP_LSB +: 3]);
    opAddr     = wb_dat_i[CMD_ADR_LSB +: 4];
    opByte     = s_q.mem[opAddr];
    execGo     = wrLow & (wb_adr_i == OFS_CMD) & (s_q.pwr == PWR_RUN);
    preTick    = (s_q.pre == PRE_LAST);
    wdtTimeout = preTick & (s_q.wdt == WDT_LAST);
  end

  // ********************************************************************
  // datapath
  // ********************************************************************
  mbd_alu u_alu (
    .op     (curOp),
    .accIn  (s_q.acc),
    .memIn  (opByte),
    .ovfIn  (s_q.ovf),
    .halfIn (s_q.half),
    .result (aluRes),
    .accWe  (aluAccWe),
    .memWe  (aluMemWe),
    .zeroWe (aluZeroWe),
    .ovfOut (aluOvf)
  );

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    // wake pin is asynchronous, so two flops before use
    s_d.wake1 = wakePin;
    s_d.wake2 = s_q.wake1;

    // watchdog keeps counting in sleep so that a timeout can wake the core
    s_d.pre = s_q.pre + 8'h01;
    if (preTick) begin
      s_d.wdt = s_q.wdt + 8'h01;
    end

    // register reads; unmapped addresses answer zero
    if (busReq) begin
      s_d.ack  = 1'b1;
      s_d.rdat = 32'h0000_0000;
      if (wb_adr_i[7:6] == MEM_PAGE) begin
        s_d.rdat[7:0] = s_q.mem[wb_adr_i[5:2]];
      end else begin
        case (wb_adr_i)
          OFS_CMD: begin
            s_d.rdat[11:0] = s_q.lastCmd;
          end
          OFS_ACC: begin
            s_d.rdat[7:0] = s_q.acc;
          end
          OFS_FLAGS: begin
            s_d.rdat[FLG_ZERO]  = s_q.zero;
            s_d.rdat[FLG_OVF]   = s_q.ovf;
            s_d.rdat[FLG_HALF]  = s_q.half;
            s_d.rdat[FLG_SLEEP] = s_q.sleep_entered_flag;
            s_d.rdat[FLG_WDOG]  = s_q.tmo;
          end
          OFS_WDT: begin
            s_d.rdat[7:0]                = s_q.wdt;
            s_d.rdat[WDT_PRE_LSB +: 8]   = s_q.pre;
          end
          default: begin
            s_d.rdat = 32'h0000_0000;
          end
        endcase
      end
    end

    // plain register writes through byte lane 0
    if (wrLow) begin
      if (wb_adr_i[7:6] == MEM_PAGE) begin
        s_d.mem[wb_adr_i[5:2]] = wb_dat_i[7:0];
      end else if (wb_adr_i == OFS_ACC) begin
        s_d.acc = wb_dat_i[7:0];
      end else if (wb_adr_i == OFS_FLAGS) begin
        s_d.zero = wb_dat_i[FLG_ZERO];
        s_d.ovf  = wb_dat_i[FLG_OVF];
        s_d.half = wb_dat_i[FLG_HALF];
      end
    end

    // operation launch; a halted core ignores command writes
    if (execGo) begin
      s_d.lastCmd = wb_dat_i[11:0];
      if (aluAccWe) begin
        s_d.acc = aluRes;
      end
      if (aluMemWe) begin
        s_d.mem[opAddr] = aluRes;
      end
      if (aluZeroWe) begin
        s_d.zero = (aluRes == 8'h00);
      end
      s_d.ovf = aluOvf;
      if (curOp == OP_SLEEP) begin
        s_d.pwr   = PWR_SLEEP;
        s_d.clkEn = 1'b0;
        s_d.pre   = 8'h00;
        s_d.wdt   = 8'h00;
        s_d.sleep_entered_flag   = 1'b1;
        s_d.tmo   = 1'b0;
      end
    end

    // sleep clears the watchdog on the same edge, so its clear beats a timeout
    if (wdtTimeout && !(execGo && curOp == OP_SLEEP)) begin
      s_d.tmo = 1'b1;
    end

    // wake on pin or watchdog; pdf stays set so software sees why
    if (s_q.pwr == PWR_SLEEP && (s_q.wake2 || wdtTimeout)) begin
      s_d.pwr   = PWR_RUN;
      s_d.clkEn = 1'b1;
    end
  end

  // ********************************************************************
  // registers
  // ********************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q         <= '0;
      s_q.acc     <= ACC_RST;
      s_q.mem     <= {MEM_WORDS{MEM_RST}};
      s_q.pwr     <= PWR_RUN;
      s_q.clkEn   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs come straight from flops
  assign wb_ack_o     = s_q.ack;
  assign wb_dat_o     = s_q.rdat;
  assign sysClkEn     = s_q.clkEn;
  assign sleepEntered = s_q.sleep_entered_flag;
  assign wdtExpired   = s_q.tmo;

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic       bcdLo;
  logic       bcdHi;
  logic [8:0] bcdRef;
  logic [7:0] bcdByte;
  logic [3:0] loNib;
  logic [3:0] hiNib;
  logic       ovfRef;
  logic       zeroRef;
  logic       cmdWhileAsleep;

  // independent reference for the decimal correction
  always_comb begin
    bcdLo  = (s_q.acc[3:0] > NIB_MAX) || s_q.half;
    bcdHi  = (s_q.acc[7:4] > NIB_MAX) || s_q.ovf;
    bcdRef = {1'b0, s_q.acc} + (bcdLo ? 9'h006 : 9'h000) + (bcdHi ? 9'h060 : 9'h000);
    bcdByte = bcdRef[7:0];
    loNib   = s_q.acc[3:0] + (bcdLo ? NIB_FIX : 4'h0);
    hiNib   = s_q.acc[7:4] + (bcdHi ? NIB_FIX : 4'h0);
    ovfRef  = bcdHi | bcdRef[8];
  end

  // zero flag worked out from the operand, so a broken alu result shows
  always_comb begin
    zeroRef = s_q.zero;
    case (curOp)
      OP_INV_ACC: begin
        zeroRef = (opByte == 8'hff);
      end
      OP_MEM_DEC, OP_DEC_ACC: begin
        zeroRef = (opByte == 8'h01);
      end
      OP_MEM_INC, OP_INC_ACC: begin
        zeroRef = (opByte == 8'hff);
      end
      default: begin
        zeroRef = s_q.zero;
      end
    endcase
  end

  // a command write that a sleeping core must ignore
  assign cmdWhileAsleep = wrLow & (wb_adr_i == OFS_CMD) & (s_q.pwr == PWR_SLEEP);

  AST_INV_ACC: assert property (
    execGo && curOp == OP_INV_ACC |=>
      s_q.acc == ~$past(opByte) && s_q.mem[$past(opAddr)] == $past(opByte)
      && s_q.ovf == $past(s_q.ovf))
    else $error("invert to accumulator wrong");

  AST_BCD_LOW: assert property (
    execGo && curOp == OP_BCD_ADJ |=>
      s_q.mem[$past(opAddr)][3:0] == $past(loNib))
    else $error("bcd low nibble correction wrong");

  AST_BCD_HIGH: assert property (
    execGo && curOp == OP_BCD_ADJ && !bcdLo |=>
      s_q.mem[$past(opAddr)][7:4] == $past(hiNib))
    else $error("bcd high nibble correction wrong");

  AST_BCD_DEST: assert property (
    execGo && curOp == OP_BCD_ADJ |=>
      s_q.mem[$past(opAddr)] == $past(bcdByte) && s_q.acc == $past(s_q.acc))
    else $error("bcd result not in memory");

  AST_BCD_FLAGS: assert property (
    execGo && curOp == OP_BCD_ADJ |=>
      s_q.ovf == $past(ovfRef) && s_q.zero == $past(s_q.zero)
      && s_q.half == $past(s_q.half))
    else $error("bcd flag effect wrong");

  AST_MEM_DEC: assert property (
    execGo && curOp == OP_MEM_DEC |=>
      s_q.mem[$past(opAddr)] == $past(opByte) - 8'h01)
    else $error("memory decrement wrong");

  AST_DEC_ACC: assert property (
    execGo && curOp == OP_DEC_ACC |=>
      s_q.acc == $past(opByte) - 8'h01 && s_q.mem[$past(opAddr)] == $past(opByte))
    else $error("decrement to accumulator wrong");

  AST_SLEEP_STOP: assert property (
    execGo && curOp == OP_SLEEP |=>
      !sysClkEn && s_q.pwr == PWR_SLEEP && s_q.acc == $past(s_q.acc))
    else $error("sleep did not stop the core");

  AST_SLEEP_HOLD: assert property (
    cmdWhileAsleep |=>
      s_q.acc == $past(s_q.acc) && s_q.mem[$past(opAddr)] == $past(opByte)
      && s_q.lastCmd == $past(s_q.lastCmd))
    else $error("command ran while asleep");

  AST_SLEEP_WDT: assert property (
    execGo && curOp == OP_SLEEP |=> s_q.wdt == 8'h00 && s_q.pre == 8'h00)
    else $error("sleep did not clear watchdog");

  AST_SLEEP_FLAGS: assert property (
    execGo && curOp == OP_SLEEP |=> sleepEntered && !wdtExpired)
    else $error("sleep flags wrong");

  AST_MEM_INC: assert property (
    execGo && curOp == OP_MEM_INC |=>
      s_q.mem[$past(opAddr)] == $past(opByte) + 8'h01
      && s_q.zero == ($past(opByte) == 8'hff))
    else $error("memory increment wrong");

  AST_INC_ACC: assert property (
    execGo && curOp == OP_INC_ACC |=>
      s_q.acc == $past(opByte) + 8'h01 && s_q.mem[$past(opAddr)] == $past(opByte))
    else $error("increment to accumulator wrong");

  AST_ZERO_FLAG: assert property (
    execGo |=> s_q.zero == $past(zeroRef))
    else $error("zero flag wrong");

  AST_BUS_ACK: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");

  COV_BCD_BOTH: cover property (execGo && curOp == OP_BCD_ADJ && bcdLo && bcdHi);
  COV_DEC_ZERO: cover property (execGo && curOp == OP_DEC_ACC && opByte == 8'h01);
  COV_SLEEP_WAKE: cover property (execGo && curOp == OP_SLEEP ##[1:40] sysClkEn);
  COV_TIMEOUT: cover property (wdtTimeout);

endmodule

//--- tb/mbd_core_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    totalChecks++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("unexpected %s: expected %h, seen %h", nm, e, g); \
    end \
  end

module mbd_core_tb;
  import mbd_pkg::*;

  // ********************************************************************
  // stimulus and observed signals
  // ********************************************************************
  logic        clk;
  logic        srst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datI;
  logic        ack;
  logic [31:0] datO;
  logic        wake;
  logic        clkEn;
  logic        slp;
  logic        wdx;
  int          failures;
  int          totalChecks;
  int          cycles;

  // adjust cases as {accumulator, half-carry, overflow}; 09 sits on the nibble boundary
  localparam logic [9:0] BCD_CASES [7] = '{{8'h00, 2'b00}, {8'h0b, 2'b00}, {8'h12, 2'b10},
    {8'ha3, 2'b00}, {8'h30, 2'b01}, {8'h99, 2'b11}, {8'h09, 2'b00}};

  mbd_core u_dut (
    .ref_clk      (clk),
    .srst         (srst),
    .wb_cyc_i     (cyc),
    .wb_stb_i     (stb),
    .wb_we_i      (we),
    .wb_adr_i     (adr),
    .wb_sel_i     (sel),
    .wb_dat_i     (datI),
    .wb_ack_o     (ack),
    .wb_dat_o     (datO),
    .wakePin      (wake),
    .sysClkEn     (clkEn),
    .sleepEntered (slp),
    .wdtExpired   (wdx)
  );

  // free-running clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard: the watchdog wait dominates, about 66k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      failures++;
      print_verdict();
    end
  end

  task print_verdict;
    if (failures == 0 && totalChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ********************************************************************
  // bus tasks
  // ********************************************************************
  // read data is taken at the ack edge, before the slave's own updates land
  task automatic busCycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    // no limit of its own: a slave that never answers is caught by the hang guard
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    busCycle(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    busCycle(1'b0, a, 32'h0, r);
  endtask

  function automatic logic [7:0] memAdr(input logic [3:0] i);
    return {MEM_PAGE, i, 2'h0};
  endfunction

  task automatic doOp(input mbd_op_t o, input logic [3:0] i);
    wr(OFS_CMD, {20'h0, i, 5'h0, o});
  endtask

  // preset byte 3, acc 3c and flags f0, run one op, read back acc, byte and flags
  task automatic runOp(input mbd_op_t o, input logic [7:0] m0, input logic [7:0] f0,
                       output logic [7:0] a, output logic [7:0] m, output logic [7:0] f);
    logic [31:0] r;
    wr(memAdr(4'h3), {24'h0, m0});
    wr(OFS_ACC, 32'h3c);
    wr(OFS_FLAGS, {24'h0, f0});
    doOp(o, 4'h3);
    rd(OFS_ACC, r);
    a = r[7:0];
    rd(memAdr(4'h3), r);
    m = r[7:0];
    rd(OFS_FLAGS, r);
    f = r[7:0];
  endtask

  // ********************************************************************
  // scenarios
  // ********************************************************************
  task automatic testReset;
    logic [31:0] r;
    rd(OFS_ACC, r);
    `CHK("reset acc", ACC_RST, r[7:0])
    rd(8'h20, r);
    `CHK("unmapped read", 32'h0, r)
    `CHK("reset flags", 3'b100, {clkEn, slp, wdx})
  endtask

  // flag presets are the inverse of the expected zero flag, so a stuck flag shows
  task automatic testInvert;
    logic [7:0] a, m, f;
    runOp(OP_INV_ACC, 8'h5a, 8'h07, a, m, f);
    `CHK("inv acc", 8'ha5, a)
    `CHK("inv mem", 8'h5a, m)
    `CHK("inv flags", 8'h06, f)
    runOp(OP_INV_ACC, 8'hff, 8'h06, a, m, f);
    `CHK("inv acc zero", 8'h00, a)
    `CHK("inv flags zero", 8'h07, f)
  endtask

  task automatic testBcd;
    logic [7:0] a;
    logic [31:0] r;
    logic h, c, lo, hi;
    logic [8:0] s;
    for (int k = 0; k < 7; k++) begin
      {a, h, c} = BCD_CASES[k];
      lo = (a[3:0] > NIB_MAX) || h;
      hi = (a[7:4] > NIB_MAX) || c;
      s = {1'b0, a} + (lo ? {5'h0, NIB_FIX} : 9'h0) + (hi ? {1'b0, NIB_FIX, 4'h0} : 9'h0);
      wr(OFS_ACC, {24'h0, a});
      wr(OFS_FLAGS, {29'h0, h, c, 1'b1});
      wr(memAdr(4'h5), 32'hee);
      doOp(OP_BCD_ADJ, 4'h5);
      rd(memAdr(4'h5), r);
      `CHK("bcd mem", s[7:0], r[7:0])
      rd(OFS_FLAGS, r);
      `CHK("bcd flags", {h, hi | s[8], 1'b1}, r[2:0])
      rd(OFS_ACC, r);
      `CHK("bcd acc", a, r[7:0])
    end
  endtask

  task automatic testDecInc;
    logic [7:0] a, m, f;
    runOp(OP_MEM_DEC, 8'h00, 8'h07, a, m, f);
    `CHK("dec mem wrap", 8'hff, m)
    `CHK("dec mem acc", 8'h3c, a)
    runOp(OP_DEC_ACC, 8'h01, 8'h06, a, m, f);
    `CHK("minus_one_to_acc_op acc", 8'h00, a)
    `CHK("minus_one_to_acc_op mem", 8'h01, m)
    `CHK("minus_one_to_acc_op flags", 8'h07, f)
    runOp(OP_DEC_ACC, 8'h00, 8'h07, a, m, f);
    `CHK("minus_one_to_acc_op acc wrap", 8'hff, a)
    `CHK("minus_one_to_acc_op flags nz", 8'h06, f)
    runOp(OP_MEM_INC, 8'hff, 8'h06, a, m, f);
    `CHK("inc mem wrap", 8'h00, m)
    `CHK("inc flags", 8'h07, f)
    runOp(OP_MEM_INC, 8'h41, 8'h07, a, m, f);
    `CHK("inc mem", 8'h42, m)
    `CHK("inc flags nz", 8'h06, f)
    runOp(OP_INC_ACC, 8'h7f, 8'h07, a, m, f);
    `CHK("plus_one_to_acc_op acc", 8'h80, a)
    `CHK("plus_one_to_acc_op mem", 8'h7f, m)
    `CHK("plus_one_to_acc_op flags", 8'h06, f)
  endtask

  // wait for a real watchdog timeout first, so that sleep has a flag to clear
  task automatic testSleep;
    logic [31:0] r;
    int n;
    wr(OFS_ACC, 32'h77);
    wr(memAdr(4'h1), 32'h11);
    n = 0;
    while (wdx !== 1'b1 && n < 70000) begin
      @(posedge clk);
      n++;
    end
    `CHK("timeout seen", 1'b1, wdx)
    doOp(OP_SLEEP, 4'h0);
    @(negedge clk);
    `CHK("clock gated", 1'b0, clkEn)
    `CHK("sleep flag", 1'b1, slp)
    `CHK("timeout flag", 1'b0, wdx)
    rd(OFS_WDT, r);
    `CHK("wdt count", 8'h00, r[7:0])
    `CHK("prescaler low", 1'b1, r[15:8] < 8'h08)
    doOp(OP_INC_ACC, 4'h1);
    rd(OFS_ACC, r);
    `CHK("acc held", 8'h77, r[7:0])
    rd(memAdr(4'h1), r);
    `CHK("mem held", 8'h11, r[7:0])
    @(posedge clk);
    wake <= 1'b1;
    n = 0;
    while (clkEn !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    wake <= 1'b0;
    `CHK("woken", 1'b1, clkEn)
    `CHK("sleep flag kept", 1'b1, slp)
    doOp(OP_INC_ACC, 4'h1);
    rd(OFS_ACC, r);
    `CHK("plus_one_to_acc_op after wake", 8'h12, r[7:0])
  endtask

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    srst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    datI = 32'h0;
    wake = 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    testReset();
    testInvert();
    testBcd();
    testDecInc();
    testSleep();
    print_verdict();
  end
endmodule
